// ### fifo_request_level_and_scanline_regs_test.sv
/*
  Self-checking bench for the fetch request and scan line register block.
  Assumes the bench is the only AHB-Lite master and drives all display inputs.
*/
`timescale 1ns/1ps
module fifo_request_level_and_scanline_regs_test;
  logic        mclk_i, rst_n_i, hwrite_i, rdy_q, hreadyout_o, hresp_o;
  logic        gfx_request_o, ov1_request_o, ov2_request_o;
  logic [1:0]  htrans_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd_q, s, v;
  logic [4:0]  gfx_empty_count_i, ov1_empty_count_i, ov2_empty_count_i;
  logic [10:0] scan_line_i;
  logic [2:0]  graphics_fetch_threshold_o, first_overlay_fetch_threshold_o;
  logic [2:0]  second_overlay_fetch_threshold_o;
  logic [7:0]  red_constant_o, green_constant_o, blue_constant_o;
  int          errors, checks, cyc;
  wire         hready_i = hreadyout_o;

  frqsl_regs i_frqsl_regs (
    .mclk_i, .rst_n_i, .hsel_i(1'b1), .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
    .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .gfx_empty_count_i,
    .ov1_empty_count_i, .ov2_empty_count_i, .scan_line_i, .gfx_request_o, .ov1_request_o,
    .ov2_request_o, .graphics_fetch_threshold_o, .first_overlay_fetch_threshold_o,
    .second_overlay_fetch_threshold_o, .red_constant_o, .green_constant_o, .blue_constant_o
  );
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  // Sampled mid-cycle so the rising edge sees settled values, not a race
  always @(negedge mclk_i)
  begin
    rd_q <= hrdata_o;
    rdy_q <= hreadyout_o;
  end
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      errors++;
      close_out();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic [4:0] lvl(input logic [2:0] c);
    return (c < 3'h5) ? c + 5'h2 : {c, 1'b0} - 5'h2;
  endfunction
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask
  // Read data is compared only for reads; write transfers pass e unused
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [31:0] e);
    @(posedge mclk_i);
    haddr_i <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= w;
    do @(posedge mclk_i); while (rdy_q !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge mclk_i); while (rdy_q !== 1'b1);
    if (!w)
      chk(e, rd_q);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    s = 32'hf5fcd7b2;
    {errors, checks, cyc} = '0;
    {rst_n_i, haddr_i, htrans_i, hwrite_i, hwdata_i, scan_line_i} = '0;
    {gfx_empty_count_i, ov1_empty_count_i, ov2_empty_count_i} = '0;
    repeat (2) @(posedge mclk_i);
    chk(32'h0, hreadyout_o);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    xfer(8'h58, 1'b0, 32'h0, 32'h0000_0444);
    xfer(8'h5c, 1'b0, 32'h0, 32'h00ed_eded);
    xfer(8'h44, 1'b0, 32'h0, 32'h0);
    chk(32'h0, hresp_o);
    chk(32'h4, graphics_fetch_threshold_o);
    gfx_empty_count_i <= 5'h06;
    ov1_empty_count_i <= 5'h05;
    ov2_empty_count_i <= 5'h06;
    repeat (3) @(posedge mclk_i);
    chk(32'h1, gfx_request_o);
    chk(32'h0, ov1_request_o);
    chk(32'h1, ov2_request_o);
    $display("reset values done");
    for (int i = 0; i < 8; i++)
    begin
      v = rnd();
      v[2:0] = i[2:0];
      v[10:8] = ~i[2:0];
      xfer(8'h58, 1'b1, v, 32'h0);
      xfer(8'h58, 1'b0, 32'h0, v & 32'h777);
      chk({29'h0, v[2:0]}, graphics_fetch_threshold_o);
      chk({29'h0, v[6:4]}, first_overlay_fetch_threshold_o);
      chk({29'h0, v[10:8]}, second_overlay_fetch_threshold_o);
      gfx_empty_count_i <= lvl(v[2:0]);
      ov1_empty_count_i <= lvl(v[6:4]) - 5'h1;
      ov2_empty_count_i <= v[31:27];
      repeat (3) @(posedge mclk_i);
      chk(32'h1, gfx_request_o);
      chk(32'h0, ov1_request_o);
      chk({31'h0, v[31:27] >= lvl(v[10:8])}, ov2_request_o);
    end
    $display("threshold codes done");
    v = rnd();
    xfer(8'h5c, 1'b1, v, 32'h0);
    xfer(8'h5c, 1'b0, 32'h0, v & 32'h00ff_ffff);
    chk({24'h0, v[23:16]}, red_constant_o);
    chk({24'h0, v[15:8]}, green_constant_o);
    chk({24'h0, v[7:0]}, blue_constant_o);
    scan_line_i <= v[10:0];
    xfer(8'h60, 1'b1, ~v, 32'h0);
    xfer(8'h60, 1'b0, 32'h0, {21'h0, v[10:0]});
    xfer(8'h5c, 1'b0, 32'h0, v & 32'h00ff_ffff);
    $display("colour and scan line done");
    close_out();
  end
endmodule

// ### frqsl_fetch_if.sv
/*
  Interface carrying one fetch FIFO's threshold code, empty count and request.
  Assumes the register module drives the code and the comparator owns the request.
*/
`timescale 1ns/1ps
interface frqsl_fetch_if #(parameter int CNT_W = 5);
  logic [2:0]       code;
  logic [CNT_W-1:0] empty_count;
  logic             request;
  modport regs (output code, output empty_count, input request);
  modport cmp  (input code, input empty_count, output request);
endinterface

// ### frqsl_pkg.sv
/*
  Package for the fetch request level and scan line register block.
  Holds register offsets, field positions, reset values and the threshold code table.
  Assumes a 32-bit AHB-Lite register bus.
*/
package frqsl_pkg;
  localparam logic [7:0]  OFS_THRESHOLD  = 8'h58;
  localparam logic [7:0]  OFS_CONVERSION = 8'h5c;
  localparam logic [7:0]  OFS_SCAN_LINE  = 8'h60;

  localparam int          GFX_LSB        = 0;
  localparam int          OV1_LSB        = 4;
  localparam int          OV2_LSB        = 8;
  localparam int          CODE_W         = 3;
  localparam int          LINE_W         = 11;
  localparam int          CONV_W         = 24;
  localparam int          RED_LSB        = 16;
  localparam int          GREEN_LSB      = 8;
  localparam int          BLUE_LSB       = 0;
  localparam int          BYTE_W         = 8;

  localparam logic [31:0] THRESHOLD_MASK = 32'h0000_0777;
  localparam logic [31:0] THRESHOLD_RST  = 32'h0000_0444;
  localparam logic [31:0] CONV_MASK      = 32'h00ff_ffff;
  localparam logic [31:0] CONV_RST       = 32'h00ed_eded;

  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ     = 2'h3;

  // Empty-entry threshold selected by a three-bit code
  function automatic logic [4:0] frqsl_level(input logic [2:0] code);
    case (code)
      3'h0:    frqsl_level = 5'h02;
      3'h1:    frqsl_level = 5'h03;
      3'h2:    frqsl_level = 5'h04;
      3'h3:    frqsl_level = 5'h05;
      3'h4:    frqsl_level = 5'h06;
      3'h5:    frqsl_level = 5'h08;
      3'h6:    frqsl_level = 5'h0a;
      default: frqsl_level = 5'h0c;
    endcase
  endfunction
endpackage

// ### frqsl_regs.sv
/*
  Fetch request threshold, colour conversion and scan line registers, AHB-Lite slave.
  Assumes a single synchronous AHB-Lite master, FIFO empty counts and a line counter
  all on mclk_i.
*/
// Decided for this implementation: the AHB-Lite interface to the registers.
// How it works
// RULE1 - each fetch FIFO requests while its empty count meets its threshold
// RULE2 - graphics code at bits 2:0 maps to 2,3,4,5,6,8,10,12 empty
// RULE3 - first overlay code at bits 6:4 uses the same mapping
// RULE4 - second overlay code at bits 10:8 uses the same mapping
// RULE5 - threshold register resets to 00000444h, six empty entries each
// RULE6 - conversion register holds red, green, blue bytes, resets to EDEDEDh
// RULE7 - scan line register reads current line in bits 10:0, read only
// RULE8 - writes to read-only or reserved bits do nothing; reserved reads zero
`timescale 1ns/1ps
module frqsl_regs #(
  parameter int CNT_W = 5
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire logic             hsel_i,
  input  wire logic [31:0]      haddr_i,
  input  wire logic [1:0]       htrans_i,
  input  wire logic             hwrite_i,
  input  wire logic [2:0]       hsize_i,
  input  wire logic [31:0]      hwdata_i,
  input  wire logic             hready_i,
  output logic      [31:0]      hrdata_o,
  output logic                  hreadyout_o,
  output logic                  hresp_o,
  input  wire logic [CNT_W-1:0] gfx_empty_count_i,
  input  wire logic [CNT_W-1:0] ov1_empty_count_i,
  input  wire logic [CNT_W-1:0] ov2_empty_count_i,
  input  wire logic [10:0]      scan_line_i,
  output logic                  gfx_request_o,
  output logic                  ov1_request_o,
  output logic                  ov2_request_o,
  output logic      [2:0]       graphics_fetch_threshold_o,
  output logic      [2:0]       first_overlay_fetch_threshold_o,
  output logic      [2:0]       second_overlay_fetch_threshold_o,
  output logic      [7:0]       red_constant_o,
  output logic      [7:0]       green_constant_o,
  output logic      [7:0]       blue_constant_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  // Assertion stays asynchronous; release is retimed so no flop leaves reset near an edge
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic nxt_rst_meta;
  logic nxt_rst_sync;

  always_comb
  begin
    nxt_rst_meta = 1'b1;
    nxt_rst_sync = rst_meta_ff;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= nxt_rst_meta;
      rst_sync_ff <= nxt_rst_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Three-bit threshold code held at a given position of the threshold word
  function automatic logic [2:0] thr_code(input logic [31:0] word, input int lsb);
    thr_code = word[lsb +: frqsl_pkg::CODE_W];
  endfunction

  // One conversion byte held at a given position of the conversion word
  function automatic logic [7:0] conv_byte(input logic [31:0] word, input int lsb);
    conv_byte = word[lsb +: frqsl_pkg::BYTE_W];
  endfunction

  // Word returned for a read; unmapped offsets and reserved bits read zero
  function automatic logic [31:0] read_word(input logic [7:0]                   ofs,
                                            input logic [31:0]                  thr,
                                            input logic [31:0]                  conv,
                                            input logic [frqsl_pkg::LINE_W-1:0] line);
    case (ofs)
      frqsl_pkg::OFS_THRESHOLD:  read_word = thr;
      frqsl_pkg::OFS_CONVERSION: read_word = conv;
      frqsl_pkg::OFS_SCAN_LINE:  read_word = {{(32-frqsl_pkg::LINE_W){1'b0}}, line}; // see RULE7
      default:                   read_word = 32'h0000_0000; // see RULE8
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture
  logic       wr_pend_ff;
  logic       rd_pend_ff;
  logic [7:0] addr_ff;
  logic       nxt_wr_pend;
  logic       nxt_rd_pend;
  logic [7:0] nxt_addr;
  logic       take;

  always_comb
  begin
    take        = hsel_i && hready_i && htrans_i[1];
    nxt_wr_pend = take && hwrite_i;
    nxt_rd_pend = take && !hwrite_i;
    nxt_addr    = take ? haddr_i[7:0] : addr_ff;
  end

  always_ff @(posedge mclk_i or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
    end
    else
    begin
      wr_pend_ff <= nxt_wr_pend;
      rd_pend_ff <= nxt_rd_pend;
      addr_ff    <= nxt_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] threshold_ff;
  logic [31:0] conv_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_threshold;
  logic [31:0] nxt_conv;
  logic [31:0] nxt_rdata;
  logic        wr_thr;
  logic        wr_conv;

  always_comb
  begin
    nxt_threshold = threshold_ff;
    nxt_conv      = conv_ff;
    wr_thr        = wr_pend_ff && (addr_ff == frqsl_pkg::OFS_THRESHOLD);
    wr_conv       = wr_pend_ff && (addr_ff == frqsl_pkg::OFS_CONVERSION);
    // Reserved bits are masked off, scan line and unmapped writes drop
    if (wr_thr)
      nxt_threshold = hwdata_i & frqsl_pkg::THRESHOLD_MASK; // see RULE2 see RULE8
    if (wr_conv)
      nxt_conv = hwdata_i & frqsl_pkg::CONV_MASK; // see RULE6 see RULE8
    // Read data registered at the address phase so hrdata_o stays a flop; a read
    // right behind a write to the same register therefore returns the old value
    nxt_rdata = 32'h0000_0000;
    if (take && !hwrite_i)
      nxt_rdata = read_word(haddr_i[7:0], threshold_ff, conv_ff, scan_line_i);
  end

  always_ff @(posedge mclk_i or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      threshold_ff <= frqsl_pkg::THRESHOLD_RST; // see RULE5
      conv_ff      <= frqsl_pkg::CONV_RST; // see RULE6
      rdata_ff     <= 32'h0000_0000;
    end
    else
    begin
      threshold_ff <= nxt_threshold;
      conv_ff      <= nxt_conv;
      rdata_ff     <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch request comparators
  frqsl_fetch_if #(.CNT_W(CNT_W)) gfx_if ();
  frqsl_fetch_if #(.CNT_W(CNT_W)) ov1_if ();
  frqsl_fetch_if #(.CNT_W(CNT_W)) ov2_if ();

  // Each request follows its FIFO count one clock late; a FIFO must allow one
  // extra entry of slack for that
  assign gfx_if.code        = thr_code(threshold_ff, frqsl_pkg::GFX_LSB); // see RULE2
  assign ov1_if.code        = thr_code(threshold_ff, frqsl_pkg::OV1_LSB); // see RULE3
  assign ov2_if.code        = thr_code(threshold_ff, frqsl_pkg::OV2_LSB); // see RULE4
  assign gfx_if.empty_count = gfx_empty_count_i;
  assign ov1_if.empty_count = ov1_empty_count_i;
  assign ov2_if.empty_count = ov2_empty_count_i;

  frqsl_request_cmp #(.CNT_W(CNT_W)) u_gfx_cmp (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_sync_ff),
    .fetch   (gfx_if.cmp)
  );
  frqsl_request_cmp #(.CNT_W(CNT_W)) u_ov1_cmp (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_sync_ff),
    .fetch   (ov1_if.cmp)
  );
  frqsl_request_cmp #(.CNT_W(CNT_W)) u_ov2_cmp (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_sync_ff),
    .fetch   (ov2_if.cmp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; all but hresp_o, tied low, come from flops in this module or the comparators
  assign hrdata_o                         = rdata_ff;
  assign hreadyout_o                      = rst_sync_ff;
  assign hresp_o                          = 1'b0;
  assign gfx_request_o                    = gfx_if.request; // see RULE1
  assign ov1_request_o                    = ov1_if.request; // see RULE1
  assign ov2_request_o                    = ov2_if.request; // see RULE1
  assign graphics_fetch_threshold_o       = thr_code(threshold_ff, frqsl_pkg::GFX_LSB);
  assign first_overlay_fetch_threshold_o  = thr_code(threshold_ff, frqsl_pkg::OV1_LSB);
  assign second_overlay_fetch_threshold_o = thr_code(threshold_ff, frqsl_pkg::OV2_LSB);
  assign red_constant_o                   = conv_byte(conv_ff, frqsl_pkg::RED_LSB);
  assign green_constant_o                 = conv_byte(conv_ff, frqsl_pkg::GREEN_LSB);
  assign blue_constant_o                  = conv_byte(conv_ff, frqsl_pkg::BLUE_LSB);
endmodule

// ### frqsl_regs_sva.sv
/*
  Checker for the fetch request threshold, conversion and scan line registers.
  Assumes it is bound into frqsl_regs and sees only that module's ports.
*/
`timescale 1ns/1ps
module frqsl_regs_sva #(
  parameter int CNT_W = 5
) (
  input wire logic             mclk_i,
  input wire logic             rst_n_i,
  input wire logic             hsel_i,
  input wire logic [31:0]      haddr_i,
  input wire logic [1:0]       htrans_i,
  input wire logic             hwrite_i,
  input wire logic [31:0]      hwdata_i,
  input wire logic             hready_i,
  input wire logic [31:0]      hrdata_o,
  input wire logic [CNT_W-1:0] gfx_empty_count_i,
  input wire logic [CNT_W-1:0] ov1_empty_count_i,
  input wire logic [CNT_W-1:0] ov2_empty_count_i,
  input wire logic [10:0]      scan_line_i,
  input wire logic             gfx_request_o,
  input wire logic             ov1_request_o,
  input wire logic             ov2_request_o,
  input wire logic [2:0]       graphics_fetch_threshold_o,
  input wire logic [2:0]       first_overlay_fetch_threshold_o,
  input wire logic [2:0]       second_overlay_fetch_threshold_o,
  input wire logic [7:0]       red_constant_o,
  input wire logic [7:0]       green_constant_o,
  input wire logic [7:0]       blue_constant_o
);
  wire       take = hsel_i && hready_i && htrans_i[1];
  wire       rd   = take && !hwrite_i;
  wire       wr   = take && hwrite_i;
  wire [7:0] ofs  = haddr_i[7:0];

  // Own copy of the code table so a slip in the shared one is not mirrored
  function automatic logic [5:0] lvl(input logic [2:0] c);
    return (c < 3'h5) ? c + 6'h2 : {c, 1'b0} - 6'h2;
  endfunction

  default clocking cb @(posedge mclk_i); endclocking
  // Own copy of the reset release, one clock behind the block's, so no check
  // starts while the block is still held
  logic [2:0] rst_pipe_ff;
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_pipe_ff <= 3'h0;
    else
      rst_pipe_ff <= {rst_pipe_ff[1:0], 1'b1};
  end
  default disable iff (!rst_pipe_ff[2]);
  //////////////////////////////////////////////////////////////////////////////
  a_gfx_request: assert property (
    ##1 gfx_request_o == ($past(gfx_empty_count_i) >= lvl($past(graphics_fetch_threshold_o))))
    else $error("graphics request wrong");
  a_ov1_request: assert property (
    ##1 ov1_request_o == ($past(ov1_empty_count_i) >= lvl($past(first_overlay_fetch_threshold_o))))
    else $error("first overlay request wrong");
  a_ov2_request: assert property (
    ##1 ov2_request_o == ($past(ov2_empty_count_i) >= lvl($past(second_overlay_fetch_threshold_o))))
    else $error("second overlay request wrong");
  a_thr_read: assert property (rd && ofs == 8'h58 |=> hrdata_o == {21'h0,
    $past(second_overlay_fetch_threshold_o), 1'b0, $past(first_overlay_fetch_threshold_o),
    1'b0, $past(graphics_fetch_threshold_o)}) else $error("threshold read wrong");
  a_thr_write: assert property (wr && ofs == 8'h58 |=> ##1
    {second_overlay_fetch_threshold_o, 1'b0, first_overlay_fetch_threshold_o, 1'b0,
    graphics_fetch_threshold_o} == ($past(hwdata_i[10:0]) & 11'h777))
    else $error("threshold write wrong");
  a_conv_read: assert property (rd && ofs == 8'h5c |=> hrdata_o == {8'h0,
    $past(red_constant_o), $past(green_constant_o), $past(blue_constant_o)})
    else $error("conversion read wrong");
  a_conv_write: assert property (wr && ofs == 8'h5c |=> ##1
    {red_constant_o, green_constant_o, blue_constant_o} == $past(hwdata_i[23:0]))
    else $error("conversion write wrong");
  a_line_read: assert property (
    rd && ofs == 8'h60 |=> hrdata_o == {21'h0, $past(scan_line_i)})
    else $error("scan line read wrong");
  c_gfx_rise: cover property ($rose(gfx_request_o));
  c_line_read: cover property (rd && ofs == 8'h60);
  c_thr_write: cover property (wr && ofs == 8'h58);
endmodule

bind frqsl_regs frqsl_regs_sva #(.CNT_W(CNT_W)) i_frqsl_regs_sva (
  .mclk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i,
  .hrdata_o, .gfx_empty_count_i, .ov1_empty_count_i, .ov2_empty_count_i, .scan_line_i,
  .gfx_request_o, .ov1_request_o, .ov2_request_o, .graphics_fetch_threshold_o,
  .first_overlay_fetch_threshold_o, .second_overlay_fetch_threshold_o,
  .red_constant_o, .green_constant_o, .blue_constant_o
);

// ### frqsl_request_cmp.sv
/*
  Request comparator for one fetch FIFO.
  Assumes the empty count is synchronous to mclk_i.
*/
`timescale 1ns/1ps
module frqsl_request_cmp #(
  parameter int CNT_W = 5
) (
  input  wire logic  mclk_i,
  input  wire logic  rst_n_i,
  frqsl_fetch_if.cmp fetch
);
  logic request_ff;
  logic nxt_request;

  always_comb
  begin
    nxt_request = ({{(8-CNT_W){1'b0}}, fetch.empty_count} >=
                   {3'h0, frqsl_pkg::frqsl_level(fetch.code)}); // see RULE1
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      request_ff <= 1'b0;
    else
      request_ff <= nxt_request;
  end

  assign fetch.request = request_ff;
endmodule
